// file: hw/slrm_pkg.sv
// Package of constants and types for the shaft light relay manager
`default_nettype none
package slrm_pkg;
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned PULSE_MS     = 500;
  localparam int unsigned SUPV_MS      = 1500;
  localparam int unsigned IDLE_HOURS   = 5;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned S_PER_HOUR   = 3600;
  // Divider producing a 1 ms tick; all timing counts run on that tick
  localparam int unsigned TICK_CYC     = CLK_HZ / MS_PER_S;
  localparam int unsigned PULSE_TICKS  = PULSE_MS;
  localparam int unsigned SUPV_TICKS   = SUPV_MS;
  localparam int unsigned IDLE_TICKS   = IDLE_HOURS * S_PER_HOUR * MS_PER_S;
  localparam logic [15:0] FAULT_CODE   = 16'h08E3; // Event 2275
  // Register offsets (word index on the plain port)
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h1;
  localparam logic [3:0]  REG_IRQ_STAT = 4'h2;
  localparam logic [3:0]  REG_IRQ_MASK = 4'h3;
  localparam logic [3:0]  REG_IDLE_LIM = 4'h4;
  localparam logic [3:0]  REG_FAULT    = 4'h5;
  // Control bit positions
  localparam int unsigned CTRL_IMPULSE = 0;
  localparam int unsigned CTRL_SW_ON   = 1;
  localparam int unsigned CTRL_SW_OFF  = 2;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;
  // Interrupt bit positions
  localparam int unsigned IRQ_FAULT    = 0;
  localparam int unsigned IRQ_AUTO_ON  = 1;
  localparam int unsigned IRQ_IDLE_OFF = 2;
  localparam int unsigned IRQ_W        = 3;
  typedef enum logic [1:0] {
    SLRM_IDLE  = 2'b00,
    SLRM_PULSE = 2'b01,
    SLRM_WAIT  = 2'b10
  } slrm_state_t;
endpackage : slrm_pkg
`default_nettype wire

// file: hw/slrm_sync_if.sv
// Interface carrying the synchronised feedback level and button edge between the input filter and the core
`default_nettype none
interface slrm_sync_if;
  logic feedback;
  logic button_rise;
  modport source (output feedback, output button_rise);
  modport sink   (input feedback, input button_rise);
endinterface : slrm_sync_if
`default_nettype wire

// file: hw/slrm_pin_sync.sv
// Three-stage synchronisers for the feedback contact and push-button pins
`default_nettype none
module slrm_pin_sync (
  input  wire logic   mclk,
  input  wire logic   reset,
  input  wire logic   feedback_pin,
  input  wire logic   button_pin,
  slrm_sync_if.source sync
);
  logic [2:0] fb_sr;
  logic [2:0] bt_sr;
  logic       fb_level;
  logic       bt_level;

  // Shift pins in; a change counts only once stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      fb_sr    <= 3'h0;
      bt_sr    <= 3'h0;
      fb_level <= 1'b0;
      bt_level <= 1'b0;
    end
    else
    begin
      fb_sr <= {fb_sr[1:0], feedback_pin};
      bt_sr <= {bt_sr[1:0], button_pin};
      if (fb_sr[1] == fb_sr[2])
        fb_level <= fb_sr[2];
      if (bt_sr[1] == bt_sr[2])
        bt_level <= bt_sr[2];
    end
  end

  // Button edge: held level rising, one pulse per press
  logic bt_level_q;
  always_ff @(posedge mclk)
  begin
    if (reset)
      bt_level_q <= 1'b0;
    else
      bt_level_q <= bt_level;
  end

  assign sync.feedback    = fb_level;
  assign sync.button_rise = bt_level & ~bt_level_q;
endmodule : slrm_pin_sync
`default_nettype wire

// file: hw/slrm_timer.sv
// Millisecond tick divider shared by the pulse, supervision and idle timers
`default_nettype none
module slrm_timer
  import slrm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input  wire logic mclk,
  input  wire logic reset,
  output logic      tick
);
  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
  logic [CW-1:0] count;

  // Free-running divider; tick is a one-cycle enable
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      tick  <= (count == LAST);
      count <= (count == LAST) ? '0 : count + CW'(1);
    end
  end
endmodule : slrm_timer
`default_nettype wire

// file: hw/slrm_core.sv
// Shaft light relay manager: relay drive, feedback supervision, auto on and idle off
//
// Implementation choices: the plain strobed port and the address map.
`default_nettype none
// Notes on behaviour
// - Impulse relay pulse lasts 500 ms
// - Fault if feedback unchanged 1500 ms after pulse
// - Manual relay toggling never raises a fault
// - Feedback always evaluated in both relay modes
// - Safety reasons with light off force light on
// - Light on idle 5 hours switched off
// - Push-button toggles light via impulse pulse
// - Without impulse relay drive on/off level outputs
// - Mismatch reported as fault event 2275
module slrm_core
  import slrm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = slrm_pkg::TICK_CYC,
  parameter int unsigned IDLE_LIMIT  = slrm_pkg::IDLE_TICKS
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        feedback_pin,
  input  wire logic        button_pin,
  input  wire logic        reason_inspection,
  input  wire logic        reason_emergency,
  input  wire logic        reason_maintenance,
  input  wire logic        reason_fire,
  input  wire logic        reason_door_supv,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             impulse_out,
  output logic             light_on_out,
  output logic             light_off_out,
  output logic             fault_event,
  output logic      [15:0] fault_code,
  output logic             irq
);
  import slrm_pkg::*;

  localparam int unsigned TW = 11;
  localparam logic [TW-1:0] PULSE_LAST = TW'(PULSE_TICKS - 1);
  localparam logic [TW-1:0] SUPV_LAST  = TW'(SUPV_TICKS - 1);
  localparam logic [31:0]   IDLE_RESET = 32'(IDLE_LIMIT);

  slrm_sync_if sync ();
  logic tick;

  slrm_pin_sync u_sync (
    .mclk         (mclk),
    .reset        (reset),
    .feedback_pin (feedback_pin),
    .button_pin   (button_pin),
    .sync         (sync.source)
  );

  slrm_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .mclk  (mclk),
    .reset (reset),
    .tick  (tick)
  );

  // Registers
  logic [31:0]        ctrl;
  logic [IRQ_W-1:0]   irq_stat;
  logic [IRQ_W-1:0]   irq_mask;
  logic [31:0]        idle_limit;
  logic [15:0]        fault_count;
  slrm_state_t        state;
  logic [TW-1:0]      tcount;
  logic [31:0]        idle_count;
  logic               target;
  logic               fb_q;

  // Decode of bus strobes and control fields
  wire impulse_mode = ctrl[CTRL_IMPULSE];
  wire wr_ctrl      = reg_wr & (reg_addr == REG_CTRL);
  wire wr_mask      = reg_wr & (reg_addr == REG_IRQ_MASK);
  wire wr_limit     = reg_wr & (reg_addr == REG_IDLE_LIM);
  wire rd_irq       = reg_rd & (reg_addr == REG_IRQ_STAT);
  wire sw_on        = wr_ctrl & reg_wdata[CTRL_SW_ON];
  wire sw_off       = wr_ctrl & reg_wdata[CTRL_SW_OFF];

  // Feedback is the only view of the light state, manual toggles included
  wire fb          = sync.feedback;
  wire reason_any  = reason_inspection | reason_emergency | reason_maintenance
                   | reason_fire | reason_door_supv;
  wire idle_expire = fb & ~reason_any & (idle_count >= idle_limit) & tick;
  wire auto_on     = reason_any & ~fb;

  // Wanted light state this cycle, requests ranked safety first
  wire want_on  = auto_on | (sync.button_rise & ~fb) | (sw_on & ~reason_any);
  wire want_off = ~reason_any & (idle_expire | (sync.button_rise & fb) | sw_off);
  // Command only when feedback disagrees, so a toggle never undoes a correct light
  wire cmd_on   = want_on & ~fb;
  wire cmd_off  = want_off & fb & ~want_on;
  wire start    = (state == SLRM_IDLE) & (cmd_on | cmd_off);

  wire timer_last_pulse = tick & (tcount == PULSE_LAST);
  wire timer_last_supv  = tick & (tcount == SUPV_LAST);
  wire reached          = (fb == target);
  wire supv_fail        = (state == SLRM_WAIT) & timer_last_supv & ~reached;

  // Command sequencer: pulse or level drive, then supervise feedback
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state  <= SLRM_IDLE;
      tcount <= '0;
      target <= 1'b0;
    end
    else
    begin
      case (state)
        SLRM_IDLE:
        begin
          tcount <= '0;
          if (start)
          begin
            target <= cmd_on;
            state  <= impulse_mode ? SLRM_PULSE : SLRM_WAIT;
          end
        end
        SLRM_PULSE:
        begin
          if (tick)
            tcount <= tcount + TW'(1);
          if (timer_last_pulse)
          begin
            state  <= SLRM_WAIT;
            tcount <= TW'(PULSE_TICKS);
          end
        end
        SLRM_WAIT:
        begin
          // Supervision counts from the pulse start, only for our own command
          if (tick)
            tcount <= tcount + TW'(1);
          if (reached | timer_last_supv)
            state <= SLRM_IDLE;
        end
        default: state <= SLRM_IDLE;
      endcase
    end
  end

  // Relay outputs from flip-flops
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      impulse_out   <= 1'b0;
      light_on_out  <= 1'b0;
      light_off_out <= 1'b0;
    end
    else
    begin
      impulse_out <= impulse_mode & (start | (state == SLRM_PULSE & ~timer_last_pulse));
      // Level outputs hold until the next command; relays stay put when idle
      if (~impulse_mode & start)
      begin
        light_on_out  <= cmd_on;
        light_off_out <= ~cmd_on;
      end
      else if (impulse_mode)
      begin
        light_on_out  <= 1'b0;
        light_off_out <= 1'b0;
      end
    end
  end

  // Idle-on timer in ms ticks; restarts whenever off or a reason is pending
  always_ff @(posedge mclk)
  begin
    if (reset)
      idle_count <= '0;
    else if (~fb | reason_any)
      idle_count <= '0;
    else if (tick & (idle_count < idle_limit))
      idle_count <= idle_count + 32'h0000_0001;
  end

  // Fault event output and counter
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      fault_event <= 1'b0;
      fault_code  <= 16'h0000;
      fault_count <= 16'h0000;
      fb_q        <= 1'b0;
    end
    else
    begin
      fb_q        <= fb;
      fault_event <= supv_fail;
      if (supv_fail)
      begin
        fault_code  <= FAULT_CODE;
        fault_count <= fault_count + 16'h0001;
      end
    end
  end

  // Software registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl       <= CTRL_RESET;
      irq_mask   <= '0;
      idle_limit <= IDLE_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= {31'h0000_0000, reg_wdata[CTRL_IMPULSE]};
      if (wr_mask)
        irq_mask <= reg_wdata[IRQ_W-1:0];
      if (wr_limit)
        idle_limit <= reg_wdata;
    end
  end

  // Sticky events; a new event in the clearing read's cycle survives
  wire [IRQ_W-1:0] events = {idle_expire & (state == SLRM_IDLE),
                             auto_on & start, supv_fail};
  always_ff @(posedge mclk)
  begin
    if (reset)
      irq_stat <= '0;
    else
      irq_stat <= (rd_irq ? '0 : irq_stat) | events;
  end

  assign irq = |(irq_stat & irq_mask);

  // Read mux, data in the cycle after the strobe
  logic [31:0] rd_mux;
  always_comb
  begin
    case (reg_addr)
      REG_CTRL:     rd_mux = ctrl;
      REG_STATUS:   rd_mux = {26'h0, light_off_out, light_on_out, impulse_out,
                              state == SLRM_IDLE, target, fb};
      REG_IRQ_STAT: rd_mux = {29'h0, irq_stat};
      REG_IRQ_MASK: rd_mux = {29'h0, irq_mask};
      REG_IDLE_LIM: rd_mux = idle_limit;
      REG_FAULT:    rd_mux = {fault_count, fault_code};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data registered; zero outside the cycle after a read strobe
  always_ff @(posedge mclk)
  begin
    if (reset)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  // Coil drive ends only out of the pulse state, never from idle or wait
  a_pulse_ends: assert property (@(posedge mclk) disable iff (reset)
    $fell(impulse_out) |-> $past(state) == SLRM_PULSE)
    else $error("impulse ended outside pulse state");

  // Ticks seen while the coil is driven, counted apart from the sequencer timer
  logic [TW-1:0] pulse_ticks_seen;
  always_ff @(posedge mclk)
  begin
    if (reset | ~impulse_out)
      pulse_ticks_seen <= '0;
    else if (tick)
      pulse_ticks_seen <= pulse_ticks_seen + TW'(1);
  end

  // A finished pulse has lasted exactly the pulse length in ms ticks
  a_pulse_length: assert property (@(posedge mclk) disable iff (reset)
    $fell(impulse_out) |-> pulse_ticks_seen == TW'(PULSE_TICKS))
    else $error("impulse length wrong");

  // Every pulse was commanded from idle in impulse mode
  a_pulse_cause: assert property (@(posedge mclk) disable iff (reset)
    $rose(impulse_out) |-> $past(start) && $past(impulse_mode))
    else $error("impulse without command");

  // A pulse always aims away from what the feedback showed
  a_pulse_needed: assert property (@(posedge mclk) disable iff (reset)
    $rose(impulse_out) |-> target != $past(fb))
    else $error("impulse toward state already shown");

  // Fault lands exactly at the end of the supervision window
  a_fault_timed: assert property (@(posedge mclk) disable iff (reset)
    $rose(fault_event) |-> $past(state) == SLRM_WAIT && $past(tcount) == SUPV_LAST)
    else $error("fault raised at wrong time");

  // Fault sets its sticky flag, even against a clearing read
  a_fault_flag: assert property (@(posedge mclk) disable iff (reset)
    supv_fail |=> irq_stat[IRQ_FAULT])
    else $error("fault flag not set");

  // Fault event is a single-cycle pulse
  a_fault_once: assert property (@(posedge mclk) disable iff (reset)
    fault_event |=> !fault_event)
    else $error("fault event longer than one cycle");

  // Fault record carries the relay supervision event number
  a_fault_code: assert property (@(posedge mclk) disable iff (reset)
    fault_event |-> fault_code == FAULT_CODE)
    else $error("fault code wrong");

  // No fault follows an idle cycle: hand toggles are not supervised
  a_no_manual_fault: assert property (@(posedge mclk) disable iff (reset)
    (state == SLRM_IDLE) |=> !fault_event)
    else $error("fault without command");

  // Level relays get exactly one of on or off, never the coil pulse
  a_level_mode: assert property (@(posedge mclk) disable iff (reset)
    !impulse_mode && start |=> light_on_out != light_off_out && !impulse_out)
    else $error("level outputs wrong");

  // Level relays keep their last command between commands
  a_level_hold: assert property (@(posedge mclk) disable iff (reset)
    !impulse_mode && !start |=> $stable(light_on_out) && $stable(light_off_out))
    else $error("level outputs moved without command");

  // Dark shaft with a reason pending is driven on at once when the sequencer is idle
  a_auto_start: assert property (@(posedge mclk) disable iff (reset)
    auto_on && state == SLRM_IDLE |=> target && (impulse_out || light_on_out))
    else $error("auto on not started");

  // Expired idle timer turns the light off when the sequencer is free
  a_idle_off: assert property (@(posedge mclk) disable iff (reset)
    idle_expire && state == SLRM_IDLE && !wr_ctrl |=> !target && state != SLRM_IDLE)
    else $error("idle expiry not acted on");

  // Pending reason holds the idle timer at zero
  a_idle_reset: assert property (@(posedge mclk) disable iff (reset)
    reason_any |=> idle_count == 32'h0)
    else $error("idle counter not restarted");

  // Read data stand only in the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge mclk) disable iff (reset)
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
endmodule : slrm_core
`default_nettype wire

// file: tb/slrm_relay_model.sv
// Behavioural shaft light relay with status contact, manual handle and stuck fault
`default_nettype none
module slrm_relay_model (
  input  wire logic mclk,
  input  wire logic pulse,
  input  wire logic on_lvl,
  input  wire logic off_lvl,
  input  wire logic manual,
  input  wire logic stuck,
  output logic      feedback
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lit      = 1'b0;
  logic pulse_d  = 1'b0;
  logic manual_d = 1'b0;
  // Toggles on each rising coil pulse edge; a stuck relay ignores the coil, not the handle
  always @(posedge mclk)
  begin
    pulse_d  <= pulse;
    manual_d <= manual;
    if (manual && !manual_d)
      lit <= !lit;
    else if (!stuck && pulse && !pulse_d)
      lit <= !lit;
    else if (!stuck && on_lvl)
      lit <= 1'b1;
    else if (!stuck && off_lvl)
      lit <= 1'b0;
  end
  // Contact closed exactly while the light is on, for either relay kind
  assign feedback = lit;
endmodule : slrm_relay_model
`default_nettype wire

// file: tb/slrm_core_test.sv
// Self-checking bench for the shaft light relay manager core
`default_nettype none
module slrm_core_test;
  timeunit 1ns;
  timeprecision 100ps;
  import slrm_pkg::*;
  localparam int TK = 4;  // Short tick keeps the run short
  localparam int IL = 20;
  logic        mclk      = 1'b0;
  logic        reset     = 1'b1;
  logic        btn       = 1'b0;
  logic        man       = 1'b0;
  logic        stuck     = 1'b0;
  logic [4:0]  rsn       = 5'h00;
  logic [3:0]  reg_addr  = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        fb, imp, lon, loff, fev, irq;
  logic [31:0] rdata, d;
  logic [15:0] fcode;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          n_fault = 0;
  int          n;
  logic [3:0]  ra [5] = '{REG_CTRL, REG_IRQ_MASK, REG_IDLE_LIM, REG_FAULT, 4'hF};
  logic [31:0] re [5] = '{CTRL_RESET, 32'h0, 32'(IL), 32'h0, 32'h0};

  always #2 mclk = ~mclk;
  // Count supervision faults seen at the port
  always @(posedge mclk)
    if (fev === 1'b1)
      n_fault++;

  slrm_core #(.TICK_CYCLES(TK), .IDLE_LIMIT(IL)) uut (
    .mclk(mclk), .reset(reset), .feedback_pin(fb), .button_pin(btn),
    .reason_inspection(rsn[0]), .reason_emergency(rsn[1]), .reason_maintenance(rsn[2]),
    .reason_fire(rsn[3]), .reason_door_supv(rsn[4]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .impulse_out(imp), .light_on_out(lon), .light_off_out(loff), .fault_event(fev),
    .fault_code(fcode), .irq(irq));

  slrm_relay_model relay (.mclk(mclk), .pulse(imp), .on_lvl(lon), .off_lvl(loff),
    .manual(man), .stuck(stuck), .feedback(fb));

  function automatic int cyc(input int ticks);
    return ticks * TK;
  endfunction : cyc

  function automatic logic [31:0] fault_word(input int cnt);
    return {cnt[15:0], FAULT_CODE};
  endfunction : fault_word

  task automatic give_verdict();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_time(input string nm, input int lo, input int hi, input int g);
    n_compared++;
    if (g < lo || g > hi)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_time

  // Bounded wait for a level; running out ends the run
  task automatic wait_for(ref logic s, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (s !== v)
    begin
      @(posedge mclk);
      cnt++;
      if (cnt > lim)
      begin
        chk_time("wait bound", 0, lim, cnt);
        give_verdict();
      end
    end
  endtask : wait_for

  task automatic pulse_seen(input int lim);
    int w;
    wait_for(imp, 1'b1, lim, w);
    wait_for(imp, 1'b0, cyc(PULSE_TICKS + 2), w);
    chk_time("pulse width", cyc(PULSE_TICKS - 1), cyc(PULSE_TICKS + 1) + 4, w);
  endtask : pulse_seen

  task automatic quiet(input int cycles);
    int c;
    c = 0;
    repeat (cycles)
    begin
      @(posedge mclk);
      if (imp !== 1'b0)
        c++;
    end
    chk_time("stray pulse cycles", 0, 0, c);
  endtask : quiet

  // Bus cycles; each returns right after a rising edge
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    v = rdata;
  endtask : rd

  initial
  begin
    void'($urandom(32'hE2D5));
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    // Reset values; the unmapped place ignores a write and reads zero
    wr(4'hF, $urandom());
    for (int i = 0; i < 5; i++)
    begin
      rd(ra[i], d);
      chk_word("reset value", re[i], d);
    end
    // Every safety reason switches a dark shaft on; idle expiry switches it off
    wr(REG_IRQ_MASK, 32'h0000_0007);
    for (int r = 0; r < 5; r++)
    begin
      repeat ($urandom_range(15)) @(posedge mclk);
      rsn <= 5'h01 << r;
      pulse_seen(cyc(SUPV_TICKS) + 50);
      chk_bit("auto light", 1'b1, fb);
      rd(REG_IRQ_STAT, d);
      chk_bit("auto on flag", 1'b1, d[IRQ_AUTO_ON]);
      chk_bit("idle off flag", r > 0, d[IRQ_IDLE_OFF]);
      rsn <= 5'h00;
      pulse_seen(cyc(SUPV_TICKS) + 200);
    end
    repeat (cyc(SUPV_TICKS)) @(posedge mclk);
    chk_bit("idle light", 1'b0, fb);
    // Manual on, then a reason: no toggle, no idle expiry; then idle delay within about a tick
    man <= 1'b1;
    repeat (10) @(posedge mclk);
    rsn <= 5'h10;
    man <= 1'b0;
    quiet(cyc(IL + 20));
    rsn <= 5'h00;
    @(posedge mclk);
    wait_for(imp, 1'b1, cyc(4 * IL), n);
    chk_time("idle off delay", cyc(IL - 1), cyc(IL + 1) + 12, n);
    wait_for(imp, 1'b0, cyc(PULSE_TICKS + 2), n);
    repeat (cyc(SUPV_TICKS)) @(posedge mclk);
    chk_bit("manual light off", 1'b0, fb);
    // Push-button toggles through the impulse relay
    btn <= 1'b1;
    pulse_seen(20);
    btn <= 1'b0;
    chk_bit("button light", 1'b1, fb);
    pulse_seen(cyc(SUPV_TICKS) + 200);
    repeat (cyc(SUPV_TICKS)) @(posedge mclk);
    chk_time("faults so far", 0, 0, n_fault);
    // Stuck relay: commanded switch-on must end in a fault, masked then unmasked
    wr(REG_IRQ_MASK, 32'h0);
    stuck <= 1'b1;
    wr(REG_CTRL, 32'h0000_0003);
    pulse_seen(20);
    wait_for(fev, 1'b1, cyc(SUPV_TICKS), n);
    chk_time("supervision time", cyc(SUPV_TICKS - PULSE_TICKS - 2),
             cyc(SUPV_TICKS - PULSE_TICKS + 2), n);
    stuck <= 1'b0;
    @(posedge mclk);
    chk_word("fault code", fault_word(0), {16'h0000, fcode});
    chk_bit("irq masked", 1'b0, irq);
    wr(REG_IRQ_MASK, 32'h0000_0001);
    chk_bit("irq unmasked", 1'b1, irq);
    rd(REG_FAULT, d);
    chk_word("fault record", fault_word(1), d);
    rd(REG_STATUS, d);
    chk_word("status after fault", 32'h0000_0006, d);
    rd(REG_IRQ_STAT, d);
    chk_bit("fault flag", 1'b1, d[IRQ_FAULT]);
    chk_bit("irq cleared", 1'b0, irq);
    // Level relays when no impulse relay is fitted
    wr(REG_CTRL, 32'h0);
    rsn <= 5'h04;
    wait_for(lon, 1'b1, 12, n);
    repeat (10) @(posedge mclk);
    chk_bit("no impulse", 1'b0, imp);
    chk_bit("level light on", 1'b1, fb);
    rd(REG_STATUS, d);
    chk_word("level status", 32'h0000_0017, d);
    rsn <= 5'h00;
    wr(REG_CTRL, 32'h0000_0004);
    wait_for(loff, 1'b1, cyc(SUPV_TICKS) + 200, n);
    repeat (10) @(posedge mclk);
    chk_bit("level light off", 1'b0, fb);
    give_verdict();
  end
endmodule : slrm_core_test
`default_nettype wire
